// *** hdl/dvam_consts.vh ***
// constants for the digital volume and auto-mute control block
`ifndef DVAM_CONSTS_VH
`define DVAM_CONSTS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DVAM_REG_AUTO_MUTE_TIME      8'h3B
`define DVAM_REG_VOLUME_LINK_CONTROL 8'h3C
`define DVAM_REG_LEFT_VOLUME         8'h3D
`define DVAM_REG_RIGHT_VOLUME        8'h3E
`define DVAM_REG_VOLUME_RAMP_NORMAL  8'h3F
`define DVAM_REG_STATUS              8'h70

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DVAM_RST_AUTO_MUTE_TIME      8'h00
`define DVAM_RST_VOLUME_LINK_CONTROL 8'h00
`define DVAM_RST_LEFT_VOLUME         8'h10
`define DVAM_RST_RIGHT_VOLUME        8'h30
`define DVAM_RST_VOLUME_RAMP_NORMAL  8'h11

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DVAM_AMT_LEFT_MSB   6
`define DVAM_AMT_LEFT_LSB   4
`define DVAM_AMT_RIGHT_MSB  2
`define DVAM_AMT_RIGHT_LSB  0
`define DVAM_AMT_MASK       8'h77
`define DVAM_LINK_MSB       1
`define DVAM_LINK_LSB       0
`define DVAM_LINK_MASK      8'h03
`define DVAM_DN_RATE_MSB    7
`define DVAM_DN_RATE_LSB    6
`define DVAM_DN_STEP_MSB    5
`define DVAM_DN_STEP_LSB    4
`define DVAM_UP_RATE_MSB    3
`define DVAM_UP_RATE_LSB    2
`define DVAM_UP_STEP_MSB    1
`define DVAM_UP_STEP_LSB    0

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define DVAM_LINK_INDEPENDENT 2'h0
`define DVAM_LINK_FOLLOW_LEFT 2'h1
`define DVAM_RATE_INSTANT     2'h3
`define DVAM_GAIN_MUTE        8'hFF
`define DVAM_GAIN_UNITY       8'h30
`define DVAM_STEP_MAX_HALF_DB 8'h08

// ----------------------------------------------------------------
// zero-run thresholds, time in microseconds at the reference rate
// ----------------------------------------------------------------
`define DVAM_REF_RATE_HZ 96000
`define DVAM_AMT_T0_US   11500
`define DVAM_AMT_T1_US   53000
`define DVAM_AMT_T2_US   106500
`define DVAM_AMT_T3_US   266500
`define DVAM_AMT_T4_US   535000
`define DVAM_AMT_T5_US   1065000
`define DVAM_AMT_T6_US   2665000
`define DVAM_AMT_T7_US   5330000
`define DVAM_US_TO_SAMPLES(t) (((t) * (`DVAM_REF_RATE_HZ / 1000)) / 1000)

`endif

// *** hdl/dvam_ctrl.v ***
// digital volume, soft mute ramp and zero-data auto mute control
//
// Overview of operation
// - left auto mute after a zero run of selected length, 11.5 ms to 5.33 s
// - right channel uses same eight thresholds from its own low 3-bit field
// - thresholds counted in samples, so durations scale with sample rate
// - link code 00 applies left and right codes independently
// - link code 01 applies the left code to both channels
// - left code 0 is +24 dB, each step -0.5 dB, 0x30 is unity
// - code 0xFE is -103 dB, code 0xFF is full mute, both channels
// - right code uses the same half-dB encoding, unity 0x30, mute 0xFF
// - ramp down updates every 1, 2 or 4 samples, or mutes instantly
// - ramp down step is 4, 2, 1 or 0.5 dB per update
// - ramp up updates every 1, 2 or 4 samples, or restores instantly
// - ramp up step is 4, 2, 1 or 0.5 dB per update
`include "dvam_consts.vh"
`default_nettype none

module dvam_ctrl #(
	parameter DATA_W        = 24,
	parameter AMT_CNT_W     = 20,
	parameter AMT_DIV       = 1
) (
	// clock and reset
	input  wire              mclk_in,
	input  wire              rst_n_in,
	// register port
	input  wire [7:0]        reg_addr_in,
	input  wire [7:0]        reg_wdata_in,
	input  wire              reg_wr_in,
	input  wire              reg_rd_in,
	output reg  [7:0]        reg_rdata_out,
	output reg               reg_rvalid_out,
	// mute request pin, low requests mute
	input  wire              soft_mute_request_pin_n_in,
	// sample input stream
	input  wire              sample_valid_in,
	output wire              sample_ready_out,
	input  wire [DATA_W-1:0] sample_left_in,
	input  wire [DATA_W-1:0] sample_right_in,
	// sample output stream with applied gain codes
	output wire              out_valid_out,
	input  wire              out_ready_in,
	output reg  [DATA_W-1:0] out_left_out,
	output reg  [DATA_W-1:0] out_right_out,
	output reg  [7:0]        out_left_gain_out,
	output reg  [7:0]        out_right_gain_out,
	// status
	output reg               left_auto_muted_out,
	output reg               right_auto_muted_out
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] auto_mute_time;
	reg [7:0] volume_link_control;
	reg [7:0] left_volume;
	reg [7:0] right_volume;
	reg [7:0] volume_ramp_normal;

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			auto_mute_time      <= `DVAM_RST_AUTO_MUTE_TIME;
			volume_link_control <= `DVAM_RST_VOLUME_LINK_CONTROL;
			left_volume         <= `DVAM_RST_LEFT_VOLUME;
			right_volume        <= `DVAM_RST_RIGHT_VOLUME;
			volume_ramp_normal  <= `DVAM_RST_VOLUME_RAMP_NORMAL;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`DVAM_REG_AUTO_MUTE_TIME:      auto_mute_time      <= reg_wdata_in & `DVAM_AMT_MASK;
				`DVAM_REG_VOLUME_LINK_CONTROL: volume_link_control <= reg_wdata_in & `DVAM_LINK_MASK;
				`DVAM_REG_LEFT_VOLUME:         left_volume         <= reg_wdata_in;
				`DVAM_REG_RIGHT_VOLUME:        right_volume        <= reg_wdata_in;
				`DVAM_REG_VOLUME_RAMP_NORMAL:  volume_ramp_normal  <= reg_wdata_in;
				default:                       ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	reg        ramp_active;
	reg  [7:0] ramp_att;
	wire [7:0] status_word;
	assign status_word = {4'h0, ramp_att == `DVAM_GAIN_MUTE, ramp_active,
		left_auto_muted_out, right_auto_muted_out};

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			reg_rdata_out  <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end
		else
		begin
			reg_rvalid_out <= reg_rd_in;
			if (reg_rd_in)
			begin
				case (reg_addr_in)
					`DVAM_REG_AUTO_MUTE_TIME:      reg_rdata_out <= auto_mute_time;
					`DVAM_REG_VOLUME_LINK_CONTROL: reg_rdata_out <= volume_link_control;
					`DVAM_REG_LEFT_VOLUME:         reg_rdata_out <= left_volume;
					`DVAM_REG_RIGHT_VOLUME:        reg_rdata_out <= right_volume;
					`DVAM_REG_VOLUME_RAMP_NORMAL:  reg_rdata_out <= volume_ramp_normal;
					`DVAM_REG_STATUS:              reg_rdata_out <= status_word;
					default:                       reg_rdata_out <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// zero-run thresholds in samples
	// ----------------------------------------------------------------
	function [AMT_CNT_W-1:0] amt_samples;
		input [2:0] code;
		reg   [31:0] n;
		begin
			n = 32'h0;
			case (code)
				3'h0:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T0_US);
				3'h1:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T1_US);
				3'h2:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T2_US);
				3'h3:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T3_US);
				3'h4:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T4_US);
				3'h5:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T5_US);
				3'h6:    n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T6_US);
				default: n = `DVAM_US_TO_SAMPLES(`DVAM_AMT_T7_US);
			endcase
			n = n / AMT_DIV;
			if (n == 32'h0)
				n = 32'h1;
			amt_samples = n[AMT_CNT_W-1:0];
		end
	endfunction

	// ----------------------------------------------------------------
	// zero-run counters
	// ----------------------------------------------------------------
	wire                 take;
	wire [AMT_CNT_W-1:0] left_thr;
	wire [AMT_CNT_W-1:0] right_thr;
	reg  [AMT_CNT_W-1:0] left_zero_cnt;
	reg  [AMT_CNT_W-1:0] right_zero_cnt;
	reg  [AMT_CNT_W-1:0] next_left_zero_cnt;
	reg  [AMT_CNT_W-1:0] next_right_zero_cnt;

	assign left_thr  = amt_samples(auto_mute_time[`DVAM_AMT_LEFT_MSB:`DVAM_AMT_LEFT_LSB]);
	assign right_thr = amt_samples(auto_mute_time[`DVAM_AMT_RIGHT_MSB:`DVAM_AMT_RIGHT_LSB]);

	always @*
	begin
		next_left_zero_cnt  = left_zero_cnt;
		next_right_zero_cnt = right_zero_cnt;
		if (take)
		begin
			if (sample_left_in != {DATA_W{1'b0}})
				next_left_zero_cnt = {AMT_CNT_W{1'b0}};
			else if (left_zero_cnt < left_thr)
				next_left_zero_cnt = left_zero_cnt + 1'b1;
			if (sample_right_in != {DATA_W{1'b0}})
				next_right_zero_cnt = {AMT_CNT_W{1'b0}};
			else if (right_zero_cnt < right_thr)
				next_right_zero_cnt = right_zero_cnt + 1'b1;
		end
	end

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			left_zero_cnt        <= {AMT_CNT_W{1'b0}};
			right_zero_cnt       <= {AMT_CNT_W{1'b0}};
			left_auto_muted_out  <= 1'b0;
			right_auto_muted_out <= 1'b0;
		end
		else
		begin
			left_zero_cnt        <= next_left_zero_cnt;
			right_zero_cnt       <= next_right_zero_cnt;
			left_auto_muted_out  <= next_left_zero_cnt >= left_thr;
			right_auto_muted_out <= next_right_zero_cnt >= right_thr;
		end
	end

	// ----------------------------------------------------------------
	// soft mute ramp, in half-dB attenuation units
	// ----------------------------------------------------------------
	wire       mute_req;
	wire [1:0] rate;
	wire [1:0] step_code;
	wire [7:0] step;
	wire [1:0] div_last;
	reg  [1:0] div_cnt;
	reg  [1:0] next_div_cnt;
	reg  [7:0] next_ramp_att;
	reg  [8:0] sum;

	assign mute_req  = !soft_mute_request_pin_n_in;
	assign rate      = mute_req ?
		volume_ramp_normal[`DVAM_DN_RATE_MSB:`DVAM_DN_RATE_LSB] :
		volume_ramp_normal[`DVAM_UP_RATE_MSB:`DVAM_UP_RATE_LSB];
	assign step_code = mute_req ?
		volume_ramp_normal[`DVAM_DN_STEP_MSB:`DVAM_DN_STEP_LSB] :
		volume_ramp_normal[`DVAM_UP_STEP_MSB:`DVAM_UP_STEP_LSB];
	assign step      = `DVAM_STEP_MAX_HALF_DB >> step_code;
	assign div_last  = (rate == 2'h0) ? 2'h0 : (rate == 2'h1) ? 2'h1 : 2'h3;

	always @*
	begin
		next_ramp_att = ramp_att;
		next_div_cnt  = div_cnt;
		sum           = 9'h000;
		if (take)
		begin
			if (rate == `DVAM_RATE_INSTANT)
			begin
				next_ramp_att = mute_req ? `DVAM_GAIN_MUTE : 8'h00;
				next_div_cnt  = 2'h0;
			end
			else if (div_cnt >= div_last)
			begin
				next_div_cnt = 2'h0;
				if (mute_req)
				begin
					sum           = {1'b0, ramp_att} + {1'b0, step};
					next_ramp_att = sum[8] ? `DVAM_GAIN_MUTE : sum[7:0];
				end
				else
					next_ramp_att = (ramp_att > step) ? ramp_att - step : 8'h00;
			end
			else
				next_div_cnt = div_cnt + 2'h1;
		end
	end

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ramp_att    <= 8'h00;
			div_cnt     <= 2'h0;
			ramp_active <= 1'b0;
		end
		else
		begin
			ramp_att    <= next_ramp_att;
			div_cnt     <= next_div_cnt;
			ramp_active <= mute_req ? (next_ramp_att != `DVAM_GAIN_MUTE) :
				(next_ramp_att != 8'h00);
		end
	end

	// ----------------------------------------------------------------
	// effective gain codes
	// ----------------------------------------------------------------
	wire [7:0] right_sel;
	reg  [8:0] left_sum;
	reg  [8:0] right_sum;
	reg  [7:0] left_eff;
	reg  [7:0] right_eff;

	assign right_sel = (volume_link_control[`DVAM_LINK_MSB:`DVAM_LINK_LSB] ==
		`DVAM_LINK_FOLLOW_LEFT) ? left_volume : right_volume;

	always @*
	begin
		left_sum  = {1'b0, left_volume} + {1'b0, ramp_att};
		right_sum = {1'b0, right_sel} + {1'b0, ramp_att};
		left_eff  = left_sum[8] ? `DVAM_GAIN_MUTE : left_sum[7:0];
		right_eff = right_sum[8] ? `DVAM_GAIN_MUTE : right_sum[7:0];
		if (left_auto_muted_out || ramp_att == `DVAM_GAIN_MUTE)
			left_eff = `DVAM_GAIN_MUTE;
		if (right_auto_muted_out || ramp_att == `DVAM_GAIN_MUTE)
			right_eff = `DVAM_GAIN_MUTE;
	end

	// ----------------------------------------------------------------
	// two-entry output buffer
	// ----------------------------------------------------------------
	localparam ENT_W = 2 * DATA_W + 16;
	reg  [ENT_W-1:0] buf_mem [0:1];
	reg              wr_ptr;
	reg              rd_ptr;
	reg  [1:0]       count;
	wire             pop;
	wire [ENT_W-1:0] head;

	assign sample_ready_out = count != 2'h2;
	assign take             = sample_valid_in && sample_ready_out;
	assign out_valid_out    = count != 2'h0;
	assign pop              = out_valid_out && out_ready_in;
	assign head             = buf_mem[rd_ptr];

	always @(posedge mclk_in)
	begin
		if (take)
			buf_mem[wr_ptr] <= {sample_left_in, sample_right_in, left_eff, right_eff};
	end

	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			if (take)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (take && !pop)
				count <= count + 2'h1;
			else if (pop && !take)
				count <= count - 2'h1;
		end
	end

	always @*
	begin
		out_left_out       = head[ENT_W-1:DATA_W+16];
		out_right_out      = head[DATA_W+15:16];
		out_left_gain_out  = head[15:8];
		out_right_gain_out = head[7:0];
	end

endmodule

`default_nettype wire

// *** bench/dvam_ctrl_chk.sv ***
// checker on the volume and auto-mute control ports
`default_nettype none
module dvam_ctrl_chk #(
	parameter DATA_W = 24
) (
	// watched ports
	input wire logic              mclk_in,
	input wire logic              rst_n_in,
	input wire logic              reg_rd_in,
	input wire logic              reg_rvalid_out,
	input wire logic              sample_valid_in,
	input wire logic              sample_ready_out,
	input wire logic [DATA_W-1:0] sample_left_in,
	input wire logic [DATA_W-1:0] sample_right_in,
	input wire logic              out_valid_out,
	input wire logic              out_ready_in,
	input wire logic [DATA_W-1:0] out_left_out,
	input wire logic [7:0]        out_left_gain_out,
	input wire logic              left_auto_muted_out,
	input wire logic              right_auto_muted_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// relations
	// --------
	wire logic take = sample_valid_in && sample_ready_out;
	wire logic zero_l = take && (sample_left_in == '0);
	wire logic nz_l = take && (sample_left_in != '0);
	wire logic nz_r = take && (sample_right_in != '0);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	chk_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read unanswered");
	chk_word_hold: assert property (out_valid_out && !out_ready_in |=>
		out_valid_out && $stable(out_left_out) && $stable(out_left_gain_out))
		else $error("word changed while stalled");
	chk_full_nonempty: assert property (!sample_ready_out |-> out_valid_out)
		else $error("full but empty");
	chk_empty_ready: assert property (!out_valid_out |-> sample_ready_out)
		else $error("empty but not ready");
	chk_left_restart: assert property (nz_l |=> !left_auto_muted_out)
		else $error("left muted after nonzero");
	chk_right_restart: assert property (nz_r |=> !right_auto_muted_out)
		else $error("right muted after nonzero");
	chk_left_rise: assert property ($rose(left_auto_muted_out) |-> $past(zero_l))
		else $error("left mute without zero sample");
	chk_mute_gain: assert property (take && left_auto_muted_out && !out_valid_out
		|=> out_left_gain_out == 8'hFF)
		else $error("muted word not at mute code");
endmodule
`default_nettype wire

// *** bench/dvam_sink_model.sv ***
// output sink that records every word it takes from the block
`default_nettype none
module dvam_sink_model (
	// clock, reset, stall control
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic        stall_in,
	// output stream of the block
	input wire logic        valid_in,
	output logic            ready_out,
	input wire logic [23:0] left_in,
	input wire logic [7:0]  gain_l_in,
	input wire logic [7:0]  gain_r_in,
	input wire logic [23:0] right_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [39:0] q [$];
	logic [23:0] qr [$];
	assign ready_out = !stall_in;
	always @(posedge clk_in)
		if (rst_n_in && valid_in && ready_out)
		begin
			q.push_back({gain_l_in, gain_r_in, left_in});
			qr.push_back(right_in);
		end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the volume and auto-mute control block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// stimulus and wires
	// --------
	logic             mclk_in = 1'b0;
	logic             rst_n_in = 1'b0;
	logic             wr_en = 1'b0;
	logic             rd_en = 1'b0;
	logic             pin_n = 1'b1;
	logic             s_valid = 1'b0;
	logic             stall = 1'b0;
	logic [7:0]       addr = 8'h00;
	logic [7:0]       wdata = 8'h00;
	logic [23:0]      s_l = 24'h000000;
	logic [23:0]      s_r = 24'h000000;
	wire logic [7:0]  rdata, g_l, g_r;
	wire logic [23:0] o_l, o_r;
	wire logic        rvalid, s_ready, o_valid, o_ready, am_l, am_r;
	int               n_errors = 0;
	int               samples_checked = 0;
	dvam_ctrl #(.DATA_W(24), .AMT_DIV(256)) u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr_en), .reg_rd_in(rd_en),
		.reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .soft_mute_request_pin_n_in(pin_n),
		.sample_valid_in(s_valid), .sample_ready_out(s_ready), .sample_left_in(s_l),
		.sample_right_in(s_r), .out_valid_out(o_valid), .out_ready_in(o_ready),
		.out_left_out(o_l), .out_right_out(o_r), .out_left_gain_out(g_l),
		.out_right_gain_out(g_r), .left_auto_muted_out(am_l), .right_auto_muted_out(am_r));
	dvam_sink_model u_sink (.clk_in(mclk_in), .rst_n_in(rst_n_in), .stall_in(stall),
		.valid_in(o_valid), .ready_out(o_ready), .left_in(o_l), .gain_l_in(g_l), .gain_r_in(g_r),
		.right_in(o_r));
	initial forever #4 mclk_in = ~mclk_in;
	task automatic compare(input logic [39:0] got, input logic [39:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic hang();
		n_errors++;
		summarize();
	endtask
	function automatic logic [7:0] sat(input int v);
		return (v > 255) ? 8'hFF : v[7:0];
	endfunction
	task automatic do_reset();
		@(posedge mclk_in) rst_n_in <= 1'b0;
		repeat (12) @(posedge mclk_in);
		rst_n_in <= 1'b1;
	endtask
	task automatic set_pin(input logic v);
		@(posedge mclk_in) pin_n <= v;
		repeat (3) @(posedge mclk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge mclk_in) wr_en <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk_in) rd_en <= 1'b0;
		@(negedge mclk_in) compare({32'h0, rdata}, {32'h0, exp});
	endtask
	task automatic send(input logic [23:0] l, input logic [23:0] r);
		int i;
		@(posedge mclk_in);
		s_l <= l;
		s_r <= r;
		s_valid <= 1'b1;
		for (i = 0; i < 64; i++)
		begin
			@(negedge mclk_in);
			if (s_ready === 1'b1)
				break;
		end
		if (i == 64)
			hang();
		@(posedge mclk_in) s_valid <= 1'b0;
	endtask
	task automatic pop_chk(input logic [39:0] exp, input logic [23:0] exp_r);
		int i;
		for (i = 0; i < 64 && u_sink.q.size() == 0; i++)
			@(negedge mclk_in);
		if (i == 64)
			hang();
		compare(u_sink.q.pop_front(), exp);
		compare({16'h0000, u_sink.qr.pop_front()}, {16'h0000, exp_r});
	endtask
	// --------
	// scenarios
	// --------
	task automatic t_regs();
		logic [15:0] rv [6] = '{16'h3B00, 16'h3C00, 16'h3D10, 16'h3E30, 16'h3F11, 16'h4000};
		logic [23:0] wv [6] = '{24'h3BFF77, 24'h3CFF03, 24'h3DA5A5, 24'h3E5A5A, 24'h3FC6C6,
			24'h40FF00};
		int k;
		for (k = 0; k < 6; k++)
			rd_chk(rv[k][15:8], rv[k][7:0]);
		for (k = 0; k < 6; k++)
		begin
			wr(wv[k][23:16], wv[k][15:8]);
			rd_chk(wv[k][23:16], wv[k][7:0]);
		end
	endtask
	task automatic t_gain();
		wr(8'h3C, 8'h00);
		wr(8'h3D, 8'h00);
		wr(8'h3E, 8'hFE);
		send(24'h000011, 24'h000022);
		pop_chk({16'h00FE, 24'h000011}, 24'h000022);
		wr(8'h3D, 8'hFF);
		wr(8'h3E, 8'h30);
		send(24'h000033, 24'h000044);
		pop_chk({16'hFF30, 24'h000033}, 24'h000044);
		wr(8'h3C, 8'h01);
		wr(8'h3D, 8'h31);
		send(24'h000055, 24'h000066);
		pop_chk({16'h3131, 24'h000055}, 24'h000066);
	endtask
	task automatic t_buffer();
		@(posedge mclk_in) stall <= 1'b1;
		send(24'h000001, 24'h000001);
		send(24'h000002, 24'h000002);
		@(negedge mclk_in) compare({39'h0, s_ready}, 40'h0);
		@(posedge mclk_in) stall <= 1'b0;
		send(24'h000003, 24'h000003);
		pop_chk({16'h3131, 24'h000001}, 24'h000001);
		pop_chk({16'h3131, 24'h000002}, 24'h000002);
		pop_chk({16'h3131, 24'h000003}, 24'h000003);
	endtask
	task automatic t_auto();
		int k;
		wr(8'h3C, 8'h00);
		wr(8'h3D, 8'h30);
		wr(8'h3B, 8'h10);
		for (k = 1; k <= 19; k++)
		begin
			send(24'h0, 24'h0);
			@(negedge mclk_in);
			if (k == 3 || k == 4 || k == 18 || k == 19)
				compare({38'h0, am_l, am_r}, {38'h0, k == 19, k >= 4});
		end
		repeat (3) @(negedge mclk_in);
		u_sink.q.delete();
		u_sink.qr.delete();
		send(24'h0, 24'h0);
		pop_chk({16'hFFFF, 24'h0}, 24'h000000);
		send(24'h000007, 24'h0);
		@(negedge mclk_in) compare({38'h0, am_l, am_r}, 40'h1);
		rd_chk(8'h70, 8'h01);
	endtask
	task automatic t_ramp();
		int r;
		int k;
		int att;
		for (r = 0; r < 4; r++)
		begin
			do_reset();
			u_sink.q.delete();
			u_sink.qr.delete();
			wr(8'h3F, {r[1:0], r[1:0], (r == 3) ? 2'h3 : 2'h0, 2'h3});
			set_pin(1'b0);
			att = 0;
			for (k = 0; k < 11; k++)
			begin
				if (k == 8)
					set_pin(1'b1);
				send(24'h000001, 24'h000001);
				pop_chk({sat(att + 16), sat(att + 48), 24'h000001}, 24'h000001);
				if (r == 3)
					att = (k < 8) ? 255 : 0;
				else if (k >= 8)
					att = att - 1;
				else if ((k + 1) % (1 << r) == 0)
					att = att + (8 >> r);
			end
		end
	endtask
	initial
	begin
		do_reset();
		t_regs();
		t_gain();
		t_buffer();
		t_auto();
		t_ramp();
		summarize();
	end
endmodule
bind dvam_ctrl dvam_ctrl_chk #(.DATA_W(DATA_W)) u_chk (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
	.reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out), .sample_valid_in(sample_valid_in),
	.sample_ready_out(sample_ready_out), .sample_left_in(sample_left_in),
	.sample_right_in(sample_right_in), .out_valid_out(out_valid_out),
	.out_ready_in(out_ready_in), .out_left_out(out_left_out),
	.out_left_gain_out(out_left_gain_out), .left_auto_muted_out(left_auto_muted_out),
	.right_auto_muted_out(right_auto_muted_out));
`default_nettype wire
